// file: rtl/gatc_top.sv
// Gain amp trim control: AHB-Lite register file, gain decode and settling timer
//
// The AHB-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
// Function
// - result low reads two bits high, rest zero
// - gain control clears to zero on reset
// - bit 7 enables stand-alone amplifier
// - bit 6 enables temperature sensor
// - bit 5 shorts amplifier inputs for trimming
// - gain field decodes bypass or seven gains
// - trim bit forces open loop, ignores gain
// - both trim registers reload 40h on reset
// - N-side bit 7 enables negative reference
// - P-side bit 7 enables positive reference
// - trim low seven bits are signed magnitude
module gatc_top #(
  parameter int unsigned SETTLE_G1_CYC  = gatc_pkg::GATC_SETTLE_G1_US * gatc_pkg::GATC_CLK_MHZ,
  parameter int unsigned SETTLE_G2_CYC  = gatc_pkg::GATC_SETTLE_G2_US * gatc_pkg::GATC_CLK_MHZ,
  parameter int unsigned SETTLE_G5_CYC  = gatc_pkg::GATC_SETTLE_G5_US * gatc_pkg::GATC_CLK_MHZ,
  parameter int unsigned SETTLE_G10_CYC = gatc_pkg::GATC_SETTLE_G10_US * gatc_pkg::GATC_CLK_MHZ,
  parameter int unsigned SETTLE_G20_CYC = gatc_pkg::GATC_SETTLE_G20_US * gatc_pkg::GATC_CLK_MHZ,
  parameter int unsigned SETTLE_G49_CYC = gatc_pkg::GATC_SETTLE_G49_US * gatc_pkg::GATC_CLK_MHZ,
  parameter int unsigned SETTLE_G98_CYC = gatc_pkg::GATC_SETTLE_G98_US * gatc_pkg::GATC_CLK_MHZ,
  parameter int unsigned SETTLE_OL_CYC  = gatc_pkg::GATC_SETTLE_OL_US * gatc_pkg::GATC_CLK_MHZ
) (
  input  wire logic                  ref_clk_i,
  input  wire logic                  rstn_i,
  // AHB-Lite slave
  input  wire logic                  hsel_i,
  input  wire logic [31:0]           haddr_i,
  input  wire logic [1:0]            htrans_i,
  input  wire logic                  hwrite_i,
  input  wire logic [2:0]            hsize_i,
  input  wire logic [31:0]           hwdata_i,
  input  wire logic                  hready_i,
  output logic [31:0]                hrdata_o,
  output logic                       hreadyout_o,
  output logic                       hresp_o,
  // Converter side, same clock
  input  wire logic [9:0]            conv_result_i,
  input  wire logic                  conv_done_i,
  input  wire logic                  channel_change_i,
  input  wire logic                  conversion_mode_select_i,
  // Analog controls
  output gatc_pkg::gatc_analog_t     analog_o,
  output logic                       settle_busy_o
);

  // Bus phase state
  logic                                   dphase_wr;
  logic                                   dphase_rd;
  logic [gatc_pkg::GATC_ADDR_BITS-1:0]    dphase_addr;
  logic                                   next_dphase_wr;
  logic                                   next_dphase_rd;
  logic [gatc_pkg::GATC_ADDR_BITS-1:0]    next_dphase_addr;

  // Register state
  gatc_pkg::gatc_gain_ctrl_t              gain_control;
  gatc_pkg::gatc_trim_t                   n_pair_offset_trim;
  gatc_pkg::gatc_trim_t                   p_pair_offset_trim;
  logic [1:0]                             result_low_bits;
  gatc_pkg::gatc_gain_ctrl_t              next_gain_control;
  gatc_pkg::gatc_trim_t                   next_n_pair_offset_trim;
  gatc_pkg::gatc_trim_t                   next_p_pair_offset_trim;
  logic [1:0]                             next_result_low_bits;

  // Settling timer and read data
  // Twenty bits hold the open-loop wait at the full clock rate
  logic [gatc_pkg::GATC_SETTLE_BITS-1:0]  settle_cnt;
  logic [gatc_pkg::GATC_SETTLE_BITS-1:0]  next_settle_cnt;
  logic [31:0]                            rdata;
  logic [31:0]                            next_rdata;
  logic                                   addr_take;
  logic                                   gain_changed;
  logic [2:0]                             next_status;

  // Amplifier powered in open loop or at any gain but bypass
  function automatic logic pga_on(
    input gatc_pkg::gatc_gain_ctrl_t cfg
  );
    return cfg.trim || cfg.gain_select != gatc_pkg::GATC_GAIN_BYPASS;
  endfunction

  // Settling count for a configuration; open loop overrides the gain field
  // Bypass gives zero, so a bypassed path never reports busy
  function automatic logic [gatc_pkg::GATC_SETTLE_BITS-1:0] settle_of(
    input gatc_pkg::gatc_gain_ctrl_t cfg
  );
    logic [gatc_pkg::GATC_SETTLE_BITS-1:0] cyc;
    cyc = '0;
    if (cfg.trim) begin
      cyc = SETTLE_OL_CYC[gatc_pkg::GATC_SETTLE_BITS-1:0];
    end else begin
      case (cfg.gain_select)
        gatc_pkg::GATC_GAIN_1:  cyc = SETTLE_G1_CYC[gatc_pkg::GATC_SETTLE_BITS-1:0];
        gatc_pkg::GATC_GAIN_2:  cyc = SETTLE_G2_CYC[gatc_pkg::GATC_SETTLE_BITS-1:0];
        gatc_pkg::GATC_GAIN_5:  cyc = SETTLE_G5_CYC[gatc_pkg::GATC_SETTLE_BITS-1:0];
        gatc_pkg::GATC_GAIN_10: cyc = SETTLE_G10_CYC[gatc_pkg::GATC_SETTLE_BITS-1:0];
        gatc_pkg::GATC_GAIN_20: cyc = SETTLE_G20_CYC[gatc_pkg::GATC_SETTLE_BITS-1:0];
        gatc_pkg::GATC_GAIN_49: cyc = SETTLE_G49_CYC[gatc_pkg::GATC_SETTLE_BITS-1:0];
        gatc_pkg::GATC_GAIN_98: cyc = SETTLE_G98_CYC[gatc_pkg::GATC_SETTLE_BITS-1:0];
        default:                cyc = '0; // Bypassed amplifier needs no settling
      endcase
    end
    return cyc;
  endfunction

  // Gain factor for the analog side; open loop and bypass drive zero
  function automatic logic [6:0] factor_of(
    input gatc_pkg::gatc_gain_ctrl_t cfg
  );
    logic [6:0] f;
    f = gatc_pkg::GATC_FACTOR_0;
    if (!cfg.trim) begin
      case (cfg.gain_select)
        gatc_pkg::GATC_GAIN_1:  f = gatc_pkg::GATC_FACTOR_1;
        gatc_pkg::GATC_GAIN_2:  f = gatc_pkg::GATC_FACTOR_2;
        gatc_pkg::GATC_GAIN_5:  f = gatc_pkg::GATC_FACTOR_5;
        gatc_pkg::GATC_GAIN_10: f = gatc_pkg::GATC_FACTOR_10;
        gatc_pkg::GATC_GAIN_20: f = gatc_pkg::GATC_FACTOR_20;
        gatc_pkg::GATC_GAIN_49: f = gatc_pkg::GATC_FACTOR_49;
        gatc_pkg::GATC_GAIN_98: f = gatc_pkg::GATC_FACTOR_98;
        default:                f = gatc_pkg::GATC_FACTOR_0;
      endcase
    end
    return f;
  endfunction

  // Register read view; next values used so a read right after a write sees it
  // Unmapped offsets return zero rather than alias a register
  function automatic logic [31:0] read_of(
    input logic [gatc_pkg::GATC_ADDR_BITS-1:0] addr,
    input gatc_pkg::gatc_gain_ctrl_t           gc,
    input gatc_pkg::gatc_trim_t                nt,
    input gatc_pkg::gatc_trim_t                pt,
    input logic [1:0]                          rl,
    input logic [2:0]                          st
  );
    logic [31:0] d;
    d = '0;
    case (addr)
      gatc_pkg::GATC_OFS_GAIN_CONTROL: d[7:0] = gc;
      gatc_pkg::GATC_OFS_N_TRIM:       d[7:0] = nt;
      gatc_pkg::GATC_OFS_P_TRIM:       d[7:0] = pt;
      gatc_pkg::GATC_OFS_RESULT_LOW:   d[gatc_pkg::GATC_RESULT_LOW_LSB +: 2] = rl;
      gatc_pkg::GATC_OFS_STATUS:       d[2:0] = st;
      default:                         d = '0; // Unmapped reads zero
    endcase
    return d;
  endfunction

  // Address phase capture; slave never stalls
  // Bus ready is always this slave's own, so no stall tracking
  always_comb begin
    addr_take        = hsel_i && hready_i && htrans_i == gatc_pkg::GATC_HTRANS_NONSEQ;
    next_dphase_wr   = addr_take && hwrite_i;
    next_dphase_rd   = addr_take && !hwrite_i;
    next_dphase_addr = addr_take ? haddr_i[gatc_pkg::GATC_ADDR_BITS-1:0] : dphase_addr;
  end

  // Data phase flags and address
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dphase_wr   <= 1'b0;
      dphase_rd   <= 1'b0;
      dphase_addr <= '0;
    end else begin
      dphase_wr   <= next_dphase_wr;
      dphase_rd   <= next_dphase_rd;
      dphase_addr <= next_dphase_addr;
    end
  end

  // Register writes land in the data phase; only a finished conversion also loads the result low bits
  // Reserved bits dropped so a stray write cannot reach the analog side
  always_comb begin
    next_gain_control       = gain_control;
    next_n_pair_offset_trim = n_pair_offset_trim;
    next_p_pair_offset_trim = p_pair_offset_trim;
    next_result_low_bits    = result_low_bits;
    if (dphase_wr) begin
      case (dphase_addr)
        gatc_pkg::GATC_OFS_GAIN_CONTROL: begin
          next_gain_control          = gatc_pkg::gatc_gain_ctrl_t'(hwdata_i[7:0]);
          next_gain_control.reserved = 2'h0; // Reserved bits kept clear, read zero
        end
        gatc_pkg::GATC_OFS_N_TRIM:     next_n_pair_offset_trim = gatc_pkg::gatc_trim_t'(hwdata_i[7:0]);
        gatc_pkg::GATC_OFS_P_TRIM:     next_p_pair_offset_trim = gatc_pkg::gatc_trim_t'(hwdata_i[7:0]);
        gatc_pkg::GATC_OFS_RESULT_LOW: next_result_low_bits = hwdata_i[gatc_pkg::GATC_RESULT_LOW_LSB +: 2];
        default:                       next_result_low_bits = result_low_bits;
      endcase
    end
    // Conversion result wins over a same-cycle software write
    if (conv_done_i) begin
      next_result_low_bits = conv_result_i[1:0];
    end
  end

  // Register storage, reset to documented values
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gain_control       <= gatc_pkg::gatc_gain_ctrl_t'(gatc_pkg::GATC_GAIN_CONTROL_RST);
      n_pair_offset_trim <= gatc_pkg::gatc_trim_t'(gatc_pkg::GATC_TRIM_RST);
      p_pair_offset_trim <= gatc_pkg::gatc_trim_t'(gatc_pkg::GATC_TRIM_RST);
      result_low_bits    <= gatc_pkg::GATC_RESULT_LOW_RST;
    end else begin
      gain_control       <= next_gain_control;
      n_pair_offset_trim <= next_n_pair_offset_trim;
      p_pair_offset_trim <= next_p_pair_offset_trim;
      result_low_bits    <= next_result_low_bits;
    end
  end

  // Settling timer restarts on the later of a channel or gain change, never adds up
  // Reload rather than add: the wait runs from the last change only
  always_comb begin
    gain_changed = next_gain_control.trim != gain_control.trim ||
                   next_gain_control.gain_select != gain_control.gain_select;
    if (gain_changed || channel_change_i) begin
      next_settle_cnt = settle_of(next_gain_control);
    end else if (settle_cnt != '0) begin
      next_settle_cnt = settle_cnt - 1'b1;
    end else begin
      next_settle_cnt = settle_cnt;
    end
  end

  // Settling counter
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      settle_cnt <= '0;
    end else begin
      settle_cnt <= next_settle_cnt;
    end
  end

  // Status bits as a read would see them after this cycle's write
  always_comb begin
    next_status                               = '0;
    next_status[gatc_pkg::GATC_STATUS_BUSY]   = next_settle_cnt != '0;
    next_status[gatc_pkg::GATC_STATUS_PGA_ON] = pga_on(next_gain_control);
    next_status[gatc_pkg::GATC_STATUS_OPEN]   = next_gain_control.trim;
  end

  // Read data registered at the address phase from the post-write view
  always_comb begin
    if (addr_take && !hwrite_i) begin
      next_rdata = read_of(haddr_i[gatc_pkg::GATC_ADDR_BITS-1:0],
                           next_gain_control,
                           next_n_pair_offset_trim,
                           next_p_pair_offset_trim,
                           next_result_low_bits,
                           next_status);
    end else begin
      next_rdata = rdata;
    end
  end

  // Read data register
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata <= '0;
    end else begin
      rdata <= next_rdata;
    end
  end

  // Gain decode and analog control outputs, all from registered state
  always_comb begin
    analog_o.standalone_amp_enable = gain_control.standalone_amp_enable;
    analog_o.temp_sensor_enable    = gain_control.temp_sensor_enable;
    analog_o.inputs_shorted        = gain_control.trim;
    analog_o.open_loop             = gain_control.trim;
    analog_o.pga_enable            = pga_on(gain_control);
    analog_o.pga_bypass            = !analog_o.pga_enable;
    analog_o.gain_factor           = factor_of(gain_control);
    // Reference enables follow the cal bits; trimming itself also needs the trim bit
    // Not gated by the trim bit here; software sequences both
    analog_o.negative_trim_reference = n_pair_offset_trim.cal_enable;
    analog_o.positive_trim_reference = p_pair_offset_trim.cal_enable;
    analog_o.mux_disable             = n_pair_offset_trim.cal_enable ||
                                       p_pair_offset_trim.cal_enable;
    analog_o.n_pair_trim_value       = n_pair_offset_trim;
    analog_o.p_pair_trim_value       = p_pair_offset_trim;
  end

  // Status and bus answer; zero wait states, always OKAY
  // No error cases exist, so the response never leaves OKAY
  assign settle_busy_o = settle_cnt != '0;
  assign hrdata_o      = rdata;
  assign hreadyout_o   = 1'b1;
  assign hresp_o       = gatc_pkg::GATC_HRESP_OKAY;

endmodule

// file: rtl/gatc_pkg.sv
// Package: register map, field layouts, reset values and settling times for the gain amp trim control
package gatc_pkg;

  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] GATC_OFS_GAIN_CONTROL = 8'h00;
  localparam logic [7:0] GATC_OFS_N_TRIM       = 8'h04;
  localparam logic [7:0] GATC_OFS_P_TRIM       = 8'h08;
  localparam logic [7:0] GATC_OFS_RESULT_LOW   = 8'h0c;
  localparam logic [7:0] GATC_OFS_STATUS       = 8'h10;
  localparam int         GATC_ADDR_BITS        = 8;

  // Reset values
  localparam logic [7:0] GATC_GAIN_CONTROL_RST = 8'h00;
  localparam logic [7:0] GATC_TRIM_RST         = 8'h40;
  localparam logic [1:0] GATC_RESULT_LOW_RST   = 2'h0;

  // Field positions
  localparam int GATC_RESULT_LOW_LSB = 6;
  localparam int GATC_STATUS_BUSY    = 0;
  localparam int GATC_STATUS_PGA_ON  = 1;
  localparam int GATC_STATUS_OPEN    = 2;

  // AHB-Lite encodings
  localparam logic [1:0] GATC_HTRANS_NONSEQ = 2'h2;
  localparam logic       GATC_HRESP_OKAY    = 1'h0;

  // Gain select codes
  typedef enum logic [2:0] {
    GATC_GAIN_BYPASS = 3'h0,
    GATC_GAIN_1      = 3'h1,
    GATC_GAIN_2      = 3'h2,
    GATC_GAIN_5      = 3'h3,
    GATC_GAIN_10     = 3'h4,
    GATC_GAIN_20     = 3'h5,
    GATC_GAIN_49     = 3'h6,
    GATC_GAIN_98     = 3'h7
  } gatc_gain_sel_t;

  // Gain control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic           standalone_amp_enable;
    logic           temp_sensor_enable;
    logic           trim;
    logic [1:0]     reserved;
    gatc_gain_sel_t gain_select;
  } gatc_gain_ctrl_t;

  // Offset trim register layout: enable, sign, magnitude
  typedef struct packed {
    logic       cal_enable;
    logic       sign;
    logic [5:0] magnitude;
  } gatc_trim_t;

  // Analog control outputs travelling together
  typedef struct packed {
    logic       standalone_amp_enable;
    logic       temp_sensor_enable;
    logic       pga_enable;
    logic       pga_bypass;
    logic       inputs_shorted;
    logic       open_loop;
    logic [6:0] gain_factor;
    logic       negative_trim_reference;
    logic       positive_trim_reference;
    logic       mux_disable;
    gatc_trim_t n_pair_trim_value;
    gatc_trim_t p_pair_trim_value;
  } gatc_analog_t;

  // Gain factors driven to the analog side
  localparam logic [6:0] GATC_FACTOR_0  = 7'h00;
  localparam logic [6:0] GATC_FACTOR_1  = 7'h01;
  localparam logic [6:0] GATC_FACTOR_2  = 7'h02;
  localparam logic [6:0] GATC_FACTOR_5  = 7'h05;
  localparam logic [6:0] GATC_FACTOR_10 = 7'h0a;
  localparam logic [6:0] GATC_FACTOR_20 = 7'h14;
  localparam logic [6:0] GATC_FACTOR_49 = 7'h31;
  localparam logic [6:0] GATC_FACTOR_98 = 7'h62;

  // Clock rate and settling times in microseconds
  localparam int GATC_CLK_MHZ       = 250;
  localparam int GATC_SETTLE_G1_US  = 9;
  localparam int GATC_SETTLE_G2_US  = 9;
  localparam int GATC_SETTLE_G5_US  = 6;
  localparam int GATC_SETTLE_G10_US = 5;
  localparam int GATC_SETTLE_G20_US = 16;
  localparam int GATC_SETTLE_G49_US = 25;
  localparam int GATC_SETTLE_G98_US = 45;
  localparam int GATC_SETTLE_OL_US  = 1050;
  localparam int GATC_SETTLE_BITS   = 20;

endpackage

// file: tb/gatc_checker_properties.sv
// Checker: concurrent properties on the gain amp trim control ports
`timescale 1ns/1ns
module gatc_checker_props (
  input wire logic                   ref_clk_i,
  input wire logic                   rstn_i,
  input wire logic                   hsel_i,
  input wire logic [31:0]            haddr_i,
  input wire logic [1:0]             htrans_i,
  input wire logic                   hwrite_i,
  input wire logic [31:0]            hwdata_i,
  input wire logic                   hready_i,
  input wire logic [31:0]            hrdata_o,
  input wire logic                   channel_change_i,
  input wire gatc_pkg::gatc_analog_t analog_o,
  input wire logic                   settle_busy_o
);
  logic       dp_wr;
  logic       dp_rd;
  logic [7:0] dp_adr;
  logic       next_dp_wr;
  logic       next_dp_rd;
  logic       taken;

  // Data phase tracking, so write data can be tied to its address
  always_comb begin
    taken = hsel_i && hready_i && htrans_i == gatc_pkg::GATC_HTRANS_NONSEQ;
    next_dp_wr = taken && hwrite_i;
    next_dp_rd = taken && !hwrite_i;
  end

  // Register the phase flags
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dp_wr  <= 1'b0;
      dp_rd  <= 1'b0;
      dp_adr <= 8'h00;
    end else begin
      dp_wr  <= next_dp_wr;
      dp_rd  <= next_dp_rd;
      dp_adr <= haddr_i[7:0];
    end
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  // Write data phase to a given register, and read data phase
  sequence s_wr(logic [7:0] a);
    dp_wr && dp_adr == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    dp_rd && dp_adr == a;
  endsequence

  AST_AMP_EN: assert property (s_wr(gatc_pkg::GATC_OFS_GAIN_CONTROL) |=>
    analog_o.standalone_amp_enable == $past(hwdata_i[7])) else $error("amp enable not from bit 7");
  AST_TS_EN: assert property (s_wr(gatc_pkg::GATC_OFS_GAIN_CONTROL) |=>
    analog_o.temp_sensor_enable == $past(hwdata_i[6])) else $error("sensor enable not from bit 6");
  AST_SHORT: assert property (s_wr(gatc_pkg::GATC_OFS_GAIN_CONTROL) |=>
    analog_o.inputs_shorted == $past(hwdata_i[5])) else $error("inputs short not from bit 5");
  AST_OPEN_LOOP: assert property (analog_o.open_loop |->
    analog_o.pga_enable && analog_o.gain_factor == 7'h00) else $error("open loop not enabled");
  AST_BYPASS: assert property (analog_o.pga_bypass |->
    !analog_o.pga_enable && !analog_o.open_loop && analog_o.gain_factor == 7'h00) else $error("bad bypass");
  AST_NREF: assert property (analog_o.negative_trim_reference == analog_o.n_pair_trim_value.cal_enable &&
    (!analog_o.negative_trim_reference || analog_o.mux_disable)) else $error("negative reference wrong");
  AST_PREF: assert property (analog_o.positive_trim_reference == analog_o.p_pair_trim_value.cal_enable &&
    (!analog_o.positive_trim_reference || analog_o.mux_disable)) else $error("positive reference wrong");
  AST_NTRIM: assert property (s_wr(gatc_pkg::GATC_OFS_N_TRIM) |=>
    analog_o.n_pair_trim_value == $past(hwdata_i[7:0])) else $error("n trim not stored");
  AST_RESULT_LOW: assert property (s_rd(gatc_pkg::GATC_OFS_RESULT_LOW) |->
    hrdata_o[31:8] == 24'h0 && hrdata_o[5:0] == 6'h00) else $error("result low bits not zero");
  AST_HOLD: assert property (!dp_wr |=> $stable(analog_o)) else $error("analog changed without write");
  AST_RST_VAL: assert property ($rose(rstn_i) |-> analog_o.pga_bypass &&
    analog_o.n_pair_trim_value == 8'h40 && analog_o.p_pair_trim_value == 8'h40 &&
    !analog_o.standalone_amp_enable && !analog_o.temp_sensor_enable) else $error("bad reset values");
  AST_CHAN_SETTLE: assert property (channel_change_i && analog_o.pga_enable |=> ##[0:1] settle_busy_o)
    else $error("no settling after channel change");
endmodule

bind gatc_top gatc_checker_props i_chk (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
  .hrdata_o(hrdata_o), .channel_change_i(channel_change_i), .analog_o(analog_o), .settle_busy_o(settle_busy_o));

// file: tb/gatc_top_tb.sv
// Testbench: register access, gain decode, trim, result and settling scenarios
`timescale 1ns/1ns
module gatc_top_tb;
  localparam int P_G2  = 12;
  localparam int P_G98 = 30;
  localparam int P_OL  = 50;
  logic                   ref_clk_i;
  logic                   rstn_i;
  logic                   hsel_i;
  logic [31:0]            haddr_i;
  logic [1:0]             htrans_i;
  logic                   hwrite_i;
  logic [31:0]            hwdata_i;
  logic [2:0]             hsize_i;
  logic                   hready_i;
  logic [31:0]            hrdata_o;
  logic                   hreadyout_o;
  logic                   hresp_o;
  logic [9:0]             conv_result_i;
  logic                   conv_done_i;
  logic                   channel_change_i;
  logic                   conversion_mode_select_i;
  gatc_pkg::gatc_analog_t analog_o;
  logic                   settle_busy_o;
  logic [31:0]            q;
  int                     fail_count = 0;
  int                     n_tests = 0;
  int                     cycles = 0;

  // Single slave, so its ready is the bus ready
  assign hready_i = hreadyout_o;

  // Short settling counts keep the run brief
  gatc_top #(.SETTLE_G1_CYC(10), .SETTLE_G2_CYC(P_G2), .SETTLE_G5_CYC(14), .SETTLE_G10_CYC(16),
    .SETTLE_G20_CYC(18), .SETTLE_G49_CYC(20), .SETTLE_G98_CYC(P_G98), .SETTLE_OL_CYC(P_OL)) i_dut (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .conv_result_i(conv_result_i), .conv_done_i(conv_done_i),
    .channel_change_i(channel_change_i), .conversion_mode_select_i(conversion_mode_select_i),
    .analog_o(analog_o), .settle_busy_o(settle_busy_o));

  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  // Hang guard, well above the expected run length
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      $display("BAD timeout exp done seen hang");
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // One AHB-Lite single transfer; read data lands in q
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    hsel_i   <= 1'b1;
    haddr_i  <= {24'h0, a};
    htrans_i <= gatc_pkg::GATC_HTRANS_NONSEQ;
    hwrite_i <= w;
    hsize_i  <= 3'h2;
    do @(posedge ref_clk_i); while (hready_i !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge ref_clk_i); while (hready_i !== 1'b1);
    q = hrdata_o;
  endtask

  // Counts busy cycles following the current edge
  task automatic busy_len(input int exp);
    int cnt = 0;
    for (int k = 0; k < 200; k++) begin
      #1;
      if (settle_busy_o === 1'b1) cnt++;
      else if (cnt > 0 || k > 3) break;
      @(posedge ref_clk_i);
    end
    chk("settle_len", cnt, exp);
  endtask

  task automatic t_reset();
    bus(1'b0, gatc_pkg::GATC_OFS_GAIN_CONTROL, 32'h0);
    chk("gain_control", q, 32'h0);
    bus(1'b0, gatc_pkg::GATC_OFS_N_TRIM, 32'h0);
    chk("n_trim", q, 32'h40);
    bus(1'b0, gatc_pkg::GATC_OFS_P_TRIM, 32'h0);
    chk("p_trim", q, 32'h40);
    chk("bypass", analog_o.pga_bypass, 32'h1);
    chk("hresp", hresp_o, 32'h0);
    bus(1'b0, 8'h14, 32'h0);
    chk("unmapped", q, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_gain();
    logic [6:0] f [8] = '{7'h00, 7'h01, 7'h02, 7'h05, 7'h0a, 7'h14, 7'h31, 7'h62};
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, gatc_pkg::GATC_OFS_GAIN_CONTROL, 32'(c));
      #1;
      chk("gain_factor", analog_o.gain_factor, f[c]);
      chk("bypass", analog_o.pga_bypass, 32'(c == 0));
    end
    bus(1'b1, gatc_pkg::GATC_OFS_GAIN_CONTROL, 32'h27);
    #1;
    chk("open_loop", {analog_o.open_loop, analog_o.inputs_shorted, analog_o.pga_enable, analog_o.gain_factor},
      {3'h7, 7'h00});
    bus(1'b1, gatc_pkg::GATC_OFS_GAIN_CONTROL, 32'hc1);
    #1;
    chk("enables", {analog_o.standalone_amp_enable, analog_o.temp_sensor_enable}, 32'h3);
    bus(1'b0, gatc_pkg::GATC_OFS_GAIN_CONTROL, 32'h0);
    chk("gain_control", q, 32'hc1);
    bus(1'b1, gatc_pkg::GATC_OFS_GAIN_CONTROL, 32'h0);
    #1;
    chk("enables", {analog_o.standalone_amp_enable, analog_o.temp_sensor_enable}, 32'h0);
    $display("test gain done");
  endtask

  task automatic t_trim();
    bus(1'b1, gatc_pkg::GATC_OFS_N_TRIM, 32'hff);
    bus(1'b1, gatc_pkg::GATC_OFS_P_TRIM, 32'h3f);
    #1;
    chk("refs", {analog_o.negative_trim_reference, analog_o.positive_trim_reference, analog_o.mux_disable},
      32'h5);
    chk("n_value", analog_o.n_pair_trim_value, 32'hff);
    chk("p_value", analog_o.p_pair_trim_value, 32'h3f);
    bus(1'b1, gatc_pkg::GATC_OFS_N_TRIM, 32'h0);
    bus(1'b1, gatc_pkg::GATC_OFS_P_TRIM, 32'h80);
    #1;
    chk("refs", {analog_o.negative_trim_reference, analog_o.positive_trim_reference, analog_o.mux_disable},
      32'h3);
    bus(1'b1, gatc_pkg::GATC_OFS_GAIN_CONTROL, 32'hc7);
    // Reset in mid-run must lose every stored setting
    @(posedge ref_clk_i);
    rstn_i <= 1'b0;
    @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    #1;
    chk("n_value", analog_o.n_pair_trim_value, 32'h40);
    chk("p_value", analog_o.p_pair_trim_value, 32'h40);
    bus(1'b0, gatc_pkg::GATC_OFS_GAIN_CONTROL, 32'h0);
    chk("gain_control", q, 32'h0);
    $display("test trim done");
  endtask

  task automatic t_result();
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk_i);
      conv_result_i <= {8'hff, 2'(i)};
      conv_done_i   <= 1'b1;
      @(posedge ref_clk_i);
      conv_done_i <= 1'b0;
      bus(1'b0, gatc_pkg::GATC_OFS_RESULT_LOW, 32'h0);
      chk("result_low", q, {24'h0, 2'(i), 6'h00});
    end
    $display("test result done");
  endtask

  task automatic t_settle();
    bus(1'b1, gatc_pkg::GATC_OFS_GAIN_CONTROL, 32'h02);
    busy_len(P_G2);
    bus(1'b1, gatc_pkg::GATC_OFS_GAIN_CONTROL, 32'h20);
    busy_len(P_OL);
    bus(1'b0, gatc_pkg::GATC_OFS_STATUS, 32'h0);
    chk("status", q, 32'h6);
    bus(1'b1, gatc_pkg::GATC_OFS_GAIN_CONTROL, 32'h07);
    busy_len(P_G98);
    // Channel change restarts the wait for the current gain
    @(posedge ref_clk_i);
    channel_change_i <= 1'b1;
    @(posedge ref_clk_i);
    channel_change_i <= 1'b0;
    busy_len(P_G98);
    bus(1'b1, gatc_pkg::GATC_OFS_GAIN_CONTROL, 32'h00);
    busy_len(0);
    $display("test settle done");
  endtask

  initial begin
    rstn_i = 1'b0;
    hsel_i = 1'b0;
    haddr_i = 32'h0;
    htrans_i = 2'h0;
    hwrite_i = 1'b0;
    hwdata_i = 32'h0;
    conv_result_i = 10'h000;
    conv_done_i = 1'b0;
    channel_change_i = 1'b0;
    hsize_i = 3'h0;
    conversion_mode_select_i = 1'b0;
    repeat (20) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_gain();
    t_trim();
    t_result();
    t_settle();
    close_out();
  end
endmodule
